// ==== bench/scm_cabinet_model.sv ====
// Purpose: Cabinet field outputs as seen by the monitor
// Assumes: The bench sets the wanted field state
// Notes: Chop gives half-wave style drive, on one cycle in three, gaps below the hold time
module scm_cabinet_model
  import scm_pkg::*;
(
  input wire logic clock,
  input wire logic [15:0] want_green,
  input wire logic [15:0] want_yellow,
  input wire logic want_card,
  input wire logic chop,
  output logic [15:0] green_on,
  output logic [15:0] yellow_on,
  output logic card_present
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] phase_ff = 2'h0;
  logic gap;
  always @(posedge clock)
  begin
    phase_ff <= (phase_ff == 2'h2) ? 2'h0 : phase_ff + 2'h1;
  end
  // No kinder than a half-wave field output: off most of the time
  assign gap = chop && (phase_ff != 2'h0);
  assign green_on = gap ? 16'h0 : want_green;
  assign yellow_on = gap ? 16'h0 : want_yellow;
  assign card_present = want_card;
endmodule

// ==== bench/signal_conflict_monitor_test.sv ====
// Purpose: Self-checking bench of the conflict monitor
// Assumes: Short trip and hold counts so the run stays brief
// Notes: Row loop for plain cases, hand-written timing, reset and bus cases after it
`include "scm_defs.svh"
module signal_conflict_monitor_test
  import scm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TRIP = 20;
  localparam int HOLD = 4;
  typedef struct packed
  {
    logic [1:0] ctrl;
    logic [1:0] aux;
    logic red;
    logic cable;
    logic [15:0] g;
    logic [15:0] y;
    logic [1:0] exp_aux;
    logic [2:0] exp_ext;
    logic [15:0] exp_led;
  } scm_row_t;
  scm_row_t rows [4] = '{
    '{2'h3, 2'h1, 1'h0, 1'h1, 16'h0001, 16'h0000, 2'h1, 3'h0, 16'h0001},
    '{2'h3, 2'h2, 1'h1, 1'h0, 16'h0000, 16'h8000, 2'h2, 3'h0, 16'h8000},
    '{2'h0, 2'h1, 1'h1, 1'h1, 16'hffff, 16'h0000, 2'h2, 3'h7, 16'hffff},
    '{2'h1, 2'h0, 1'h1, 1'h1, 16'h00f0, 16'h0f00, 2'h2, 3'h7, 16'h0ff0}};
  logic clock, resetn, want_card, chop, card_present, red_enable, red_monitor_cable_socket;
  logic panel_reset_btn, ext_reset_in, failed, conflict_led, card_ajar_led, irq;
  logic [15:0] want_green, want_yellow, green_on, yellow_on, channel_led;
  logic [119:0] compat_fitted;
  logic [1:0] aux_func_in, aux_enabled, bresp, rresp, rs;
  logic [2:0] ext_chk_en;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0] wstrb;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int fail_count, checks_done, n;

  scm_cabinet_model cab_u (.clock(clock), .want_green(want_green), .want_yellow(want_yellow),
    .want_card(want_card), .chop(chop), .green_on(green_on), .yellow_on(yellow_on), .card_present(card_present));
  scm_monitor #(.NCH(16), .TRIP_CYC(TRIP), .HOLD_CYC(HOLD)) dut_u (.clock(clock), .resetn(resetn),
    .green_on(green_on), .yellow_on(yellow_on), .compat_fitted(compat_fitted), .card_present(card_present),
    .red_enable(red_enable), .red_monitor_cable_socket(red_monitor_cable_socket), .aux_func_in(aux_func_in),
    .panel_reset_btn(panel_reset_btn), .ext_reset_in(ext_reset_in), .failed(failed), .conflict_led(conflict_led),
    .card_ajar_led(card_ajar_led), .channel_led(channel_led), .ext_chk_en(ext_chk_en), .aux_enabled(aux_enabled),
    .irq(irq), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The slave takes address and data at one edge, so both are released together
  task axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    @(posedge clock);
    while (awready !== 1'h1 || wready !== 1'h1)
      @(posedge clock);
    awvalid <= 1'h0;
    wvalid <= 1'h0;
    bready <= 1'h1;
    @(posedge clock);
    while (bvalid !== 1'h1)
      @(posedge clock);
    r = bresp;
    bready <= 1'h0;
  endtask

  task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    @(posedge clock);
    while (arready !== 1'h1)
      @(posedge clock);
    arvalid <= 1'h0;
    rready <= 1'h1;
    @(posedge clock);
    while (rvalid !== 1'h1)
      @(posedge clock);
    d = rdata;
    r = rresp;
    rready <= 1'h0;
  endtask

  task wait_fail(input int lim);
    n = 0;
    while (failed !== 1'h1 && n < lim)
    begin
      @(posedge clock);
      n++;
    end
  endtask

  task complete_run;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    clock = 1'h0;
    forever
      #2 clock = ~clock;
  end

  initial
  begin
    #80000;
    fail_count++;
    $display("watchdog expired");
    complete_run;
  end

  initial
  begin
    {resetn, want_green, want_yellow, chop, compat_fitted, red_enable, red_monitor_cable_socket} = '0;
    {aux_func_in, panel_reset_btn, ext_reset_in, awaddr, wdata, awvalid, wvalid, bready} = '0;
    {araddr, arvalid, rready, fail_count, checks_done} = '0;
    want_card = 1'h1;
    wstrb = 4'hf;
    repeat (12) @(posedge clock);
    resetn <= 1'h1;
    axi_rd(`SCM_OFF_CTRL, rd, rs);
    chk("ctrl_reset", 32'h3, rd);
    axi_rd(`SCM_OFF_IRQ_MASK, rd, rs);
    chk("mask_reset", 32'h0, rd);
    axi_rd(`SCM_OFF_IRQ_STAT, rd, rs);
    chk("stat_reset", 32'h0, rd);
    chk("failed_reset", 32'h0, failed);
    $display("reset test done");
    foreach (rows[i])
    begin
      axi_wr(`SCM_OFF_CTRL, {30'h0, rows[i].ctrl}, rs);
      aux_func_in <= rows[i].aux;
      red_enable <= rows[i].red;
      red_monitor_cable_socket <= rows[i].cable;
      want_green <= rows[i].g;
      want_yellow <= rows[i].y;
      repeat (HOLD + 4) @(posedge clock);
      chk("aux_enabled", rows[i].exp_aux, aux_enabled);
      chk("ext_chk_en", rows[i].exp_ext, ext_chk_en);
      chk("channel_led", rows[i].exp_led, channel_led);
    end
    $display("row test done");
    // Only the pair of channels 3 and 7 is fitted
    compat_fitted <= 120'h1 << 45;
    want_green <= 16'h0108;
    want_yellow <= 16'h0000;
    repeat (40) @(posedge clock);
    chk("permitted_pair", 32'h0, failed);
    want_green <= 16'h0008;
    want_yellow <= 16'h0080;
    repeat (TRIP - HOLD - 6) @(posedge clock);
    want_green <= 16'h0000;
    want_yellow <= 16'h0000;
    repeat (30) @(posedge clock);
    chk("short_conflict", 32'h0, failed);
    // Brief conflict on the first pair of the table, broken well before the trip count
    compat_fitted <= 120'h1;
    want_green <= 16'h0001;
    want_yellow <= 16'h0002;
    repeat (2) @(posedge clock);
    axi_rd(`SCM_OFF_STATUS, rd, rs);
    chk("status_conflict", 32'h2, rd & 32'h2);
    axi_rd(`SCM_OFF_CHAN_LIVE, rd, rs);
    chk("chan_live", 32'h0003, rd);
    want_green <= 16'h0000;
    want_yellow <= 16'h0000;
    compat_fitted <= 120'h1 << 45;
    repeat (10) @(posedge clock);
    chk("brief_pair", 32'h0, failed);
    chop <= 1'h1;
    want_green <= 16'h0008;
    want_yellow <= 16'h0080;
    @(posedge clock);
    wait_fail(TRIP * 3);
    chk("trip_window", 32'h1, n >= TRIP && n <= TRIP + 6);
    chop <= 1'h0;
    want_green <= 16'h0000;
    want_yellow <= 16'h0000;
    repeat (10) @(posedge clock);
    chk("failed_latched", 32'h1, failed);
    chk("conflict_led", 32'h1, conflict_led);
    chk("led_frozen", 32'h0088, channel_led);
    axi_rd(`SCM_OFF_FAIL_SNAP, rd, rs);
    chk("fail_snap", 32'h0088, rd);
    axi_rd(`SCM_OFF_IRQ_STAT, rd, rs);
    chk("stat_fail", 32'h1, rd);
    chk("irq_masked", 32'h0, irq);
    axi_wr(`SCM_OFF_IRQ_MASK, 32'h1, rs);
    chk("irq_on", 32'h1, irq);
    axi_wr(`SCM_OFF_IRQ_STAT, 32'h1, rs);
    chk("irq_cleared", 32'h0, irq);
    $display("conflict test done");
    ext_reset_in <= 1'h1;
    repeat (3) @(posedge clock);
    chk("unit_reset", 32'h0, failed);
    chk("conflict_led_off", 32'h0, conflict_led);
    axi_rd(`SCM_OFF_IRQ_STAT, rd, rs);
    chk("stat_unit_reset", 32'h4, rd);
    chk("irq_bit_masked", 32'h0, irq);
    axi_wr(`SCM_OFF_IRQ_STAT, 32'h7, rs);
    want_card <= 1'h0;
    repeat (3) @(posedge clock);
    chk("card_out_fail", 32'h1, failed);
    chk("card_ajar_led", 32'h1, card_ajar_led);
    axi_rd(`SCM_OFF_STATUS, rd, rs);
    chk("status_card", 32'h1, rd & 32'h5);
    want_card <= 1'h1;
    repeat (5) @(posedge clock);
    chk("held_reset_level", 32'h1, failed);
    axi_rd(`SCM_OFF_IRQ_STAT, rd, rs);
    chk("stat_card", 32'h3, rd);
    ext_reset_in <= 1'h0;
    // The two sources are ORed, so the level must drop before a new press counts
    repeat (2) @(posedge clock);
    chk("falling_edge_ignored", 32'h1, failed);
    panel_reset_btn <= 1'h1;
    repeat (3) @(posedge clock);
    chk("panel_reset", 32'h0, failed);
    chk("card_led_off", 32'h0, card_ajar_led);
    panel_reset_btn <= 1'h0;
    $display("unit reset test done");
    axi_wr(`SCM_OFF_STATUS, 32'h0, rs);
    chk("ro_write", `SCM_RESP_SLVERR, rs);
    axi_wr(8'h40, 32'h1, rs);
    chk("unmapped_write", `SCM_RESP_SLVERR, rs);
    axi_rd(8'h40, rd, rs);
    chk("unmapped_read", `SCM_RESP_SLVERR, rs);
    chk("unmapped_data", 32'h0, rd);
    wstrb <= 4'h0;
    axi_wr(`SCM_OFF_IRQ_MASK, 32'h6, rs);
    axi_rd(`SCM_OFF_IRQ_MASK, rd, rs);
    chk("strobe_off_write", 32'h1, rd);
    wstrb <= 4'hf;
    $display("bus test done");
    want_card <= 1'h0;
    repeat (3) @(posedge clock);
    resetn <= 1'h0;
    want_card <= 1'h1;
    repeat (4) @(posedge clock);
    chk("failed_in_reset", 32'h0, failed);
    chk("rvalid_in_reset", 32'h0, rvalid);
    resetn <= 1'h1;
    axi_rd(`SCM_OFF_CTRL, rd, rs);
    chk("ctrl_mid_reset", 32'h3, rd);
    chk("failed_mid_reset", 32'h0, failed);
    $display("mid-run reset test done");
    complete_run;
  end
endmodule

// ==== design/scm_defs.svh ====
// Purpose: Register offsets, field positions, reset values, clock rate and millisecond timing limits of the conflict monitor
// Assumes: 250 MHz core clock, 32-bit AXI4-Lite register bus
// Notes: Definitions only
`ifndef SCM_DEFS_SVH
`define SCM_DEFS_SVH

`define SCM_ADDR_W 8
`define SCM_OFF_CTRL 8'h00
`define SCM_OFF_STATUS 8'h04
`define SCM_OFF_IRQ_STAT 8'h08
`define SCM_OFF_IRQ_MASK 8'h0c
`define SCM_OFF_CHAN_LIVE 8'h10
`define SCM_OFF_FAIL_SNAP 8'h14

`define SCM_CTRL_AUX_POL_LSB 0
`define SCM_CTRL_RST 2'h3
`define SCM_MASK_RST 3'h0

`define SCM_ST_FAILED 0
`define SCM_ST_CONFLICT 1
`define SCM_ST_CARD_OK 2
`define SCM_ST_EXT_MODE 3
`define SCM_ST_AUX_EN_LSB 4

`define SCM_EV_FAIL 0
`define SCM_EV_CARD_OUT 1
`define SCM_EV_UNIT_RST 2
`define SCM_EV_W 3

`define SCM_CLK_KHZ 250000
`define SCM_TRIP_MS 300
`define SCM_MIN_MS 200
`define SCM_MAX_MS 450
`define SCM_HOLD_MS 12

`define SCM_RESP_OKAY 2'h0
`define SCM_RESP_SLVERR 2'h2

`endif

// ==== design/scm_monitor.sv ====
// Purpose: Conflict detection core of a cabinet safety monitor with an AXI4-Lite register window
// Assumes: Channel inputs arrive as synchronous on/off decisions from the analog threshold stage
// Notes: Failure is latched until the leading edge of a panel or external unit reset
//
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`include "scm_defs.svh"

// Functional notes
// - Without red enable, only basic checks run
// - Red enable with the red monitor cable fitted adds lack, multiple, yellow checks
// - Per-aux-input selectable enabling polarity
// - Input on drives its channel indicator; the code holds the indicators at the failure snapshot while failed
// - On decision independent of active channel count
// - Half-wave inputs held on across gaps
// - Conflict held to upper limit forces failure
// - Conflict at or below lower limit never fails
// - Trip time chosen inside the allowed band
// - Card entry per pair: fitted means conflicting
// - Failure latched until unit reset leading edge
// - Missing compatibility card forces failure
module scm_monitor
  import scm_pkg::*;
#(
  parameter int NCH = 16,
  parameter int TRIP_CYC = `SCM_TRIP_MS * `SCM_CLK_KHZ,
  parameter int HOLD_CYC = `SCM_HOLD_MS * `SCM_CLK_KHZ
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [NCH-1:0] green_on,
  input wire logic [NCH-1:0] yellow_on,
  input wire logic [NCH*(NCH-1)/2-1:0] compat_fitted,
  input wire logic card_present,
  input wire logic red_enable,
  input wire logic red_monitor_cable_socket,
  input wire logic [1:0] aux_func_in,
  input wire logic panel_reset_btn,
  input wire logic ext_reset_in,
  output logic failed,
  output logic conflict_led,
  output logic card_ajar_led,
  output logic [NCH-1:0] channel_led,
  output logic [2:0] ext_chk_en,
  output logic [1:0] aux_enabled,
  output logic irq,
  input wire logic [`SCM_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`SCM_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int NPAIR = NCH * (NCH - 1) / 2;
  localparam int MAX_CYC = `SCM_MAX_MS * `SCM_CLK_KHZ;
  localparam int MIN_CYC = `SCM_MIN_MS * `SCM_CLK_KHZ;
  localparam int TCW = $clog2(MAX_CYC) + 2;
  localparam int HCW = $clog2(HOLD_CYC + 1) + 1;

  if (NCH < 2 || NCH > 30 || TRIP_CYC < 1 || TRIP_CYC > MAX_CYC || HOLD_CYC < 1)
  begin : g_bad_param
    $error("scm_monitor: parameter out of range");
  end

  // Input qualification: each input has its own hold timer, so no input
  // influences another's decision; the hold bridges the dead half of a
  // half-wave signal at either polarity
  logic [2*NCH-1:0] raw_on;
  logic [2*NCH-1:0] held_on;
  logic [NCH-1:0] chan_on;

  assign raw_on = {yellow_on, green_on};

  for (genvar k = 0; k < 2 * NCH; k++)
  begin : g_hold
    logic [HCW-1:0] hold_ff;

    always_ff @(posedge clock or negedge resetn)
    begin
      if (!resetn)
        hold_ff <= '0;
      else if (raw_on[k])
        hold_ff <= HCW'(HOLD_CYC);
      else if (hold_ff != '0)
        hold_ff <= hold_ff - HCW'(1);
    end

    assign held_on[k] = raw_on[k] || (hold_ff != '0);
  end

  assign chan_on = held_on[NCH-1:0] | held_on[2*NCH-1:NCH];

  // Pair table: one card entry per unordered channel pair, row by row
  logic [NPAIR-1:0] pair_hit;
  logic conflict_now;

  for (genvar i = 0; i < NCH; i++)
  begin : g_row
    for (genvar j = i + 1; j < NCH; j++)
    begin : g_col
      localparam int IDX = i * (2 * NCH - i - 1) / 2 + (j - i - 1);
      assign pair_hit[IDX] = chan_on[i] && chan_on[j] && compat_fitted[IDX];
    end
  end

  assign conflict_now = |pair_hit;

  // Unit reset acts on the leading edge only, so a stuck button or a
  // constant external level cannot hold the monitor out of the failed state
  logic unit_rst_lvl;
  logic unit_rst_prev_ff;
  logic unit_rst_edge;

  assign unit_rst_lvl = panel_reset_btn || ext_reset_in;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      unit_rst_prev_ff <= 1'b1;
    else
      unit_rst_prev_ff <= unit_rst_lvl;
  end

  assign unit_rst_edge = unit_rst_lvl && !unit_rst_prev_ff;

  // Conflict persistence
  logic [TCW-1:0] run_cnt;
  logic trip;

  scm_persist_timer #(
    .CW(TCW),
    .LIMIT(TRIP_CYC)
  ) u_trip (
    .clock(clock),
    .resetn(resetn),
    .active(conflict_now),
    .clear(unit_rst_edge),
    .count(run_cnt),
    .expired(trip)
  );

  // Failure latch; a cause present in the reset cycle wins over the reset
  logic failed_ff;
  logic conflict_led_ff;
  logic card_ajar_ff;
  logic fail_set;
  logic [NCH-1:0] snap_ff;
  logic [NCH-1:0] led_ff;

  assign fail_set = trip || !card_present;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      failed_ff <= 1'b0;
    else if (fail_set)
      failed_ff <= 1'b1;
    else if (unit_rst_edge)
      failed_ff <= 1'b0;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      conflict_led_ff <= 1'b0;
    else if (trip)
      conflict_led_ff <= 1'b1;
    else if (unit_rst_edge)
      conflict_led_ff <= 1'b0;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      card_ajar_ff <= 1'b0;
    else if (!card_present)
      card_ajar_ff <= 1'b1;
    else if (unit_rst_edge)
      card_ajar_ff <= 1'b0;
  end

  // Channel picture frozen at the moment of failure for later review
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      snap_ff <= '0;
    else if (fail_set && !failed_ff)
      snap_ff <= chan_on;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      led_ff <= '0;
    else if (failed_ff)
      led_ff <= snap_ff;
    else
      led_ff <= chan_on;
  end

  // Operating mode and auxiliary inputs
  logic [1:0] ctrl_ff;
  logic ext_ff;
  logic [1:0] aux_en_ff;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ext_ff <= 1'b0;
    else
      ext_ff <= red_enable && red_monitor_cable_socket;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      aux_en_ff <= '0;
    else
      aux_en_ff <= ~(aux_func_in ^ ctrl_ff);
  end

  // Register bus: write address and data are taken together
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic wr_take;
  logic wr_hit;
  logic [2:0] mask_ff;
  logic [2:0] stat_ff;
  logic [2:0] ev;
  logic [2:0] w1c;
  logic fail_prev_ff;
  logic card_prev_ff;

  assign wr_take = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign s_axi_awready = wr_take;
  assign s_axi_wready = wr_take;
  assign wr_hit = (s_axi_awaddr == `SCM_OFF_CTRL) || (s_axi_awaddr == `SCM_OFF_IRQ_STAT) ||
                  (s_axi_awaddr == `SCM_OFF_IRQ_MASK);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `SCM_RESP_OKAY;
    end
    else if (wr_take)
    begin
      bvalid_ff <= 1'b1;
      bresp_ff <= wr_hit ? `SCM_RESP_OKAY : `SCM_RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_ff <= 1'b0;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      ctrl_ff <= `SCM_CTRL_RST;
    else if (wr_take && s_axi_awaddr == `SCM_OFF_CTRL && s_axi_wstrb[0])
      ctrl_ff <= s_axi_wdata[`SCM_CTRL_AUX_POL_LSB +: 2];
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      mask_ff <= `SCM_MASK_RST;
    else if (wr_take && s_axi_awaddr == `SCM_OFF_IRQ_MASK && s_axi_wstrb[0])
      mask_ff <= s_axi_wdata[2:0];
  end

  // Interrupt events; a new event beats a write-one-to-clear in the same cycle
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      fail_prev_ff <= 1'b0;
      card_prev_ff <= 1'b1;
    end
    else
    begin
      fail_prev_ff <= failed_ff;
      card_prev_ff <= card_present;
    end
  end

  assign ev[`SCM_EV_FAIL] = failed_ff && !fail_prev_ff;
  assign ev[`SCM_EV_CARD_OUT] = card_prev_ff && !card_present;
  assign ev[`SCM_EV_UNIT_RST] = unit_rst_edge;
  assign w1c = (wr_take && s_axi_awaddr == `SCM_OFF_IRQ_STAT && s_axi_wstrb[0]) ? s_axi_wdata[2:0] : 3'h0;

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      stat_ff <= '0;
    else
      stat_ff <= (stat_ff & ~w1c) | ev;
  end

  // Register bus: reads answer one cycle after the address is taken
  scm_rd_state_t rd_state_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rd_word;
  logic rd_hit;
  logic [31:0] status_word;

  assign s_axi_arready = (rd_state_ff == SCM_RD_IDLE);
  assign status_word = {26'h0, aux_en_ff, ext_ff, card_present, conflict_now, failed_ff};

  always_comb
  begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `SCM_OFF_CTRL: rd_word = {30'h0, ctrl_ff};
      `SCM_OFF_STATUS: rd_word = status_word;
      `SCM_OFF_IRQ_STAT: rd_word = {29'h0, stat_ff};
      `SCM_OFF_IRQ_MASK: rd_word = {29'h0, mask_ff};
      `SCM_OFF_CHAN_LIVE: rd_word = 32'(chan_on);
      `SCM_OFF_FAIL_SNAP: rd_word = 32'(snap_ff);
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_state_ff <= SCM_RD_IDLE;
      rdata_ff <= 32'h0;
      rresp_ff <= `SCM_RESP_OKAY;
    end
    else
    begin
      case (rd_state_ff)
        SCM_RD_IDLE:
        begin
          if (s_axi_arvalid)
          begin
            rd_state_ff <= SCM_RD_RESP;
            rdata_ff <= rd_word;
            rresp_ff <= rd_hit ? `SCM_RESP_OKAY : `SCM_RESP_SLVERR;
          end
        end
        SCM_RD_RESP:
        begin
          if (s_axi_rready)
            rd_state_ff <= SCM_RD_IDLE;
        end
        default: rd_state_ff <= SCM_RD_IDLE;
      endcase
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = (rd_state_ff == SCM_RD_RESP);
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign failed = failed_ff;
  assign conflict_led = conflict_led_ff;
  assign card_ajar_led = card_ajar_ff;
  assign channel_led = led_ff;
  assign ext_chk_en = {3{ext_ff}};
  assign aux_enabled = aux_en_ff;
  assign irq = |(stat_ff & mask_ff);

  // Checks
  property p_basic_only;
    @(posedge clock) disable iff (!resetn)
    !red_monitor_cable_socket |=> (ext_chk_en == 3'h0);
  endproperty
  a_basic_only: assert property (p_basic_only) else $error("extended checks active without red cable");

  property p_ext_on;
    @(posedge clock) disable iff (!resetn)
    (red_enable && red_monitor_cable_socket) |=> (ext_chk_en == 3'h7);
  endproperty
  a_ext_on: assert property (p_ext_on) else $error("extended checks not enabled with red enable");

  property p_aux_pol;
    @(posedge clock) disable iff (!resetn)
    ##1 aux_enabled == ~($past(aux_func_in) ^ $past(ctrl_ff));
  endproperty
  a_aux_pol: assert property (p_aux_pol) else $error("aux enable does not follow selected polarity");

  property p_led_live;
    @(posedge clock) disable iff (!resetn)
    !failed_ff |=> (channel_led == $past(chan_on));
  endproperty
  a_led_live: assert property (p_led_live) else $error("channel indicator does not follow input");

  sequence s_pulse_then_gap;
    raw_on[0] ##1 !raw_on[0];
  endsequence

  property p_hold_gap;
    @(posedge clock) disable iff (!resetn)
    s_pulse_then_gap |-> held_on[0];
  endproperty
  a_hold_gap: assert property (p_hold_gap) else $error("input dropped during half-wave gap");

  property p_trip_to_fail;
    @(posedge clock) disable iff (!resetn)
    trip |=> failed_ff && conflict_led;
  endproperty
  a_trip_to_fail: assert property (p_trip_to_fail) else $error("persistent conflict did not fail");

  property p_no_early_trip;
    @(posedge clock) disable iff (!resetn)
    $rose(failed_ff) && $past(card_present) |-> $past(run_cnt) >= TCW'(TRIP_CYC);
  endproperty
  a_no_early_trip: assert property (p_no_early_trip) else $error("failed before the trip time");

  sequence s_rst_held;
    unit_rst_lvl [*2];
  endsequence

  property p_level_no_clear;
    @(posedge clock) disable iff (!resetn)
    s_rst_held ##0 failed_ff |=> failed_ff;
  endproperty
  a_level_no_clear: assert property (p_level_no_clear) else $error("held reset level cleared failure");

  property p_card_fail;
    @(posedge clock) disable iff (!resetn)
    !card_present |=> failed_ff && card_ajar_led;
  endproperty
  a_card_fail: assert property (p_card_fail) else $error("missing card did not fail");

  property p_pair_flag;
    @(posedge clock) disable iff (!resetn)
    (green_on[0] && yellow_on[1] && compat_fitted[0]) |-> conflict_now;
  endproperty
  a_pair_flag: assert property (p_pair_flag) else $error("fitted pair both on not flagged");

  property p_irq_fail;
    @(posedge clock) disable iff (!resetn)
    $rose(failed_ff) |=> stat_ff[`SCM_EV_FAIL];
  endproperty
  a_irq_fail: assert property (p_irq_fail) else $error("failure event not recorded");
endmodule

// ==== design/scm_persist_timer.sv ====
// Purpose: Counts how long a condition has held without a break
// Assumes: active is a level from the same clock domain
// Notes: expired stays high while the condition keeps holding past LIMIT
module scm_persist_timer
  import scm_pkg::*;
#(
  parameter int CW = 27,
  parameter int LIMIT = 75000000
)
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic active,
  input wire logic clear,
  output logic [CW-1:0] count,
  output logic expired
);
  localparam logic [CW-1:0] LIM = CW'(LIMIT);

  logic [CW-1:0] count_ff;

  if (LIMIT < 1 || LIMIT >= (2 ** (CW - 1)))
  begin : g_bad_limit
    $error("scm_persist_timer: LIMIT does not fit CW");
  end

  // Any break in the condition restarts the measurement
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      count_ff <= '0;
    else if (!active || clear)
      count_ff <= '0;
    else if (count_ff < LIM)
      count_ff <= count_ff + CW'(1);
  end

  assign count = count_ff;
  assign expired = (count_ff == LIM);

  property p_never_past_limit;
    @(posedge clock) disable iff (!resetn)
    count_ff <= LIM;
  endproperty
  a_never_past_limit: assert property (p_never_past_limit) else $error("timer count ran past its limit");

  property p_break_restarts;
    @(posedge clock) disable iff (!resetn)
    !active |=> (count_ff == '0);
  endproperty
  a_break_restarts: assert property (p_break_restarts) else $error("timer kept counting over a break");
endmodule

// ==== design/scm_pkg.sv ====
// Purpose: Shared types of the conflict monitor
// Assumes: Nothing beyond the defs header
// Notes: Types only; numbers live in scm_defs.svh
package scm_pkg;
  typedef enum logic [1:0]
  {
    SCM_RD_IDLE = 2'b00,
    SCM_RD_RESP = 2'b01
  } scm_rd_state_t;
endpackage
